// ---- acd_angle_core.v ----
// angle calculation, output mapping and configuration supervision core
`timescale 1ns/1ps
`include "acdiag_map.vh"
// What this block does
// R1: cancel offsets, cordic, then zero and range
// R2: angle 180-degree periodic from programmable zero
// R3: linear output, rising or falling slope
// R4: above max below switch gives upper clamp
// R5: above switch gives lower clamp
// R6: falling slope exchanges clamp levels
// R7: valid codes between clamps, extremes mean error
// R8: crc over words 0 to 14, checked against stored word 15 at power-on
// R9: 16-bit words stored as 22-bit codes
// R10: single bit error corrected, operation continues
// R11: multiple bit errors enter diagnostic mode
// R12: weak field raises diagnostic condition
// R13: active diagnostic forces crc/magnet errors out
// R14: two free 16-bit user registers
// R15: 32-bit user identifier held in memory
// R16: memory reached only via the apb memory address, write data and read data registers
// R17: low supply sets status bit
// R18: hold diagnostic level during initialisation
// R19: diagnostic persists until next reset
// R20: one output code per angle computation
module acd_angle_core #(
    parameter WORDS = `ACD_MEM_WORDS
) (
    input  wire        mclk,
    input  wire        reset,
    input  wire        adcValid,
    input  wire        adcSel,
    input  wire [15:0] adcData,
    input  wire        lowSupply,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg  [11:0] dacCode,
    output reg         dacValid
);
    // ********************************************************
    // configuration memory, 22-bit protected words
    // ********************************************************
    // word 0 ctrl, 1 zero, 2 range, 3 lower clamp, 4 upper clamp, 5 switch,
    // 6/7 user regs, 8/9 identifier, 10 magnet min, 15 stored crc
    reg [21:0] mem [0:WORDS-1];                         // see R9
    reg [3:0]  memAddr;
    reg [15:0] cfg [0:WORDS-1];
    reg [15:0] crc;
    reg [3:0]  scanIdx;
    reg        scanning;
    reg        crcBad;
    reg        multiErr;
    reg        corrSeen;
    reg        magLoss;
    reg        lowSupSt;
    reg        diag;
    reg [15:0] offSin;
    reg [15:0] offCos;
    reg [15:0] rawSin;
    reg [15:0] rawCos;
    reg        haveSin;
    reg        cordStart;
    wire [15:0] wordData;
    wire        wordCorr;
    wire        wordMulti;
    wire        cordDone;
    wire [15:0] angle;
    wire [17:0] mag;
    function [21:0] encode;
        input [15:0] d;
        reg   [21:0] c;
        reg   [4:0]  s;
        integer      i;
        integer      k;
        begin
            c = 22'h000000;
            k = 0;
            for (i = 3; i < 22; i = i + 1) begin
                if (i != 4 && i != 8 && i != 16) begin
                    c[i] = d[k];
                    k = k + 1;
                end
            end
            s = 5'h00;
            for (i = 1; i < 22; i = i + 1) begin
                if (c[i]) begin
                    s = s ^ i[4:0];
                end
            end
            c[1] = s[0];
            c[2] = s[1];
            c[4] = s[2];
            c[8] = s[3];
            c[16] = s[4];
            c[0] = ^c[21:1];
            encode = c;
        end
    endfunction
    function [15:0] crcStep;
        input [15:0] cin;
        input [15:0] d;
        reg   [15:0] c;
        integer      i;
        begin
            c = cin;
            for (i = 15; i >= 0; i = i - 1) begin
                if (c[15] ^ d[i]) begin
                    c = {c[14:0], 1'b0} ^ `ACD_CRC_POLY;
                end else begin
                    c = {c[14:0], 1'b0};
                end
            end
            crcStep = c;
        end
    endfunction
    acd_word_protect uProt (
        .codeIn     (mem[memAddr]),
        .dataOut    (wordData),
        .corrected  (wordCorr),
        .multiError (wordMulti)
    );
    // ********************************************************
    // power-on scan: decode every word, crc, load shadow copies
    // ********************************************************
    wire apbAcc = psel && penable;
    wire apbWr  = apbAcc && pwrite;
    wire memWr  = apbWr && paddr == `ACD_MEMWDATA;
    integer j;
    always @(posedge mclk) begin
        if (reset) begin
            scanning <= 1'b1;
            scanIdx <= 4'h0;
            crc <= `ACD_CRC_INIT;
            crcBad <= 1'b0;
            multiErr <= 1'b0;
            corrSeen <= 1'b0;
            memAddr <= 4'h0;
            for (j = 0; j < WORDS; j = j + 1) begin
                cfg[j] <= 16'h0000;
            end
        end else if (scanning) begin
            cfg[scanIdx] <= wordData;
            if (wordMulti) begin
                multiErr <= 1'b1;                       // see R11
            end
            if (wordCorr) begin
                corrSeen <= 1'b1;                       // see R10
            end
            if (scanIdx == WORDS - 1) begin
                scanning <= 1'b0;
                crcBad <= crc != wordData;              // see R8
            end else begin
                crc <= crcStep(crc, wordData);
                scanIdx <= scanIdx + 4'h1;
                memAddr <= scanIdx + 4'h1;
            end
        end else if (apbWr && paddr == `ACD_MEMADDR) begin
            memAddr <= pwdata[3:0];
        end
    end
    // writes go straight to storage; new settings take effect after next reset
    always @(posedge mclk) begin
        if (memWr && !scanning) begin
            mem[memAddr] <= encode(pwdata[15:0]);    // see R16
        end
    end
    // ********************************************************
    // sample pairing, offset cancellation, cordic
    // ********************************************************
    always @(posedge mclk) begin
        if (reset) begin
            rawSin <= 16'h0000;
            rawCos <= 16'h0000;
            haveSin <= 1'b0;
            cordStart <= 1'b0;
        end else begin
            cordStart <= 1'b0;
            if (adcValid && !adcSel) begin
                rawSin <= adcData - offSin;              // see R1
                haveSin <= 1'b1;
            end else if (adcValid && adcSel && haveSin) begin
                rawCos <= adcData - offCos;
                haveSin <= 1'b0;
                cordStart <= !scanning;
            end
        end
    end
    acd_cordic #(
        .ITER (14)
    ) uCordic (
        .mclk      (mclk),
        .reset     (reset),
        .start     (cordStart),
        .sinIn     (rawSin),
        .cosIn     (rawCos),
        .done      (cordDone),
        .angle     (angle),
        .magnitude (mag)
    );
    // ********************************************************
    // zero, range, slope, clamping and diagnostic selection
    // ********************************************************
    wire [15:0] ctrl   = cfg[0];
    wire [15:0] rel    = angle - cfg[1];                // see R2
    wire        fall   = ctrl[`ACD_CTRL_FALL];
    wire [11:0] cll    = cfg[3][11:0];
    wire [11:0] clu    = cfg[4][11:0];
    wire [11:0] span   = clu - cll;
    wire [27:0] prod   = rel * span;
    wire [15:0] rng    = (cfg[2] == 16'h0000) ? 16'h0001 : cfg[2];
    wire [27:0] quo    = prod / rng;
    wire [11:0] lin    = quo[11:0];
    wire [11:0] diagLv = ctrl[`ACD_CTRL_DHIGH] ? `ACD_DIAG_HIGH : `ACD_DIAG_LOW;
    reg  [11:0] next_dacCode;
    always @* begin
        if (rel <= cfg[2]) begin
            next_dacCode = fall ? clu - lin : cll + lin;   // see R3
        end else if (rel < cfg[5]) begin
            next_dacCode = fall ? cll : clu;               // see R4 see R6
        end else begin
            next_dacCode = fall ? clu : cll;               // see R5 see R6
        end
        if (diag) begin
            next_dacCode = diagLv;                         // see R7 see R19
        end
    end
    always @(posedge mclk) begin
        if (reset) begin
            diag <= 1'b0;
            magLoss <= 1'b0;
            lowSupSt <= 1'b0;
            offSin <= 16'h0000;
            offCos <= 16'h0000;
            dacCode <= `ACD_DIAG_LOW;
            dacValid <= 1'b0;
        end else begin
            dacValid <= 1'b0;
            if (lowSupply) begin
                lowSupSt <= 1'b1;                          // see R17
            end
            if (scanning) begin
                dacCode <= diagLv;                         // see R18
                offSin <= cfg[11];
                offCos <= cfg[12];
            end else begin
                if (cordDone && mag[17:2] < cfg[10]) begin
                    magLoss <= 1'b1;                       // see R12
                end
                if (multiErr || (ctrl[`ACD_CTRL_ACTD] && (crcBad || magLoss))) begin
                    diag <= 1'b1;                          // see R13 see R19
                end
                if (diag) begin
                    dacCode <= diagLv;                     // see R13 see R19
                end else if (cordDone) begin
                    dacCode <= next_dacCode;               // see R20
                end
                if (cordDone) begin
                    dacValid <= 1'b1;
                end
            end
        end
    end
    // ********************************************************
    // apb slave, zero wait states
    // ********************************************************
    always @(posedge mclk) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && !penable) begin
                case (paddr)
                    `ACD_CTRL:     prdata <= {16'h0000, cfg[0]};
                    `ACD_ZERO:     prdata <= {16'h0000, cfg[1]};
                    `ACD_RANGE:    prdata <= {16'h0000, cfg[2]};
                    `ACD_CLAMP:    prdata <= {4'h0, clu, 4'h0, cll};
                    `ACD_SWITCH:   prdata <= {16'h0000, cfg[5]};
                    `ACD_STATUS:   prdata <= {25'h0, !scanning, diag, corrSeen, lowSupSt,
                                              magLoss, multiErr, crcBad};
                    `ACD_OUTPUT:   prdata <= {20'h00000, dacCode};
                    `ACD_USER0:    prdata <= {16'h0000, cfg[6]};          // see R14
                    `ACD_USER1:    prdata <= {16'h0000, cfg[7]};
                    `ACD_IDENT:    prdata <= {cfg[9], cfg[8]};            // see R15
                    `ACD_MEMADDR:  prdata <= {28'h0000000, memAddr};
                    `ACD_MEMWDATA: prdata <= 32'h0000_0000;
                    `ACD_MEMRDATA: prdata <= {16'h0000, wordData};
                    `ACD_MAGMIN:   prdata <= {16'h0000, cfg[10]};
                    default:       pslverr <= 1'b1;
                endcase
            end
        end
    end
endmodule // acd_angle_core

// ---- acd_cordic.v ----
// iterative vectoring cordic giving a 180-degree periodic angle
`timescale 1ns/1ps
module acd_cordic #(
    parameter ITER = 14
) (
    input  wire        mclk,
    input  wire        reset,
    input  wire        start,
    input  wire [15:0] sinIn,
    input  wire [15:0] cosIn,
    output reg         done,
    output reg  [15:0] angle,
    output reg  [17:0] magnitude
);
    reg [17:0] x;
    reg [17:0] y;
    reg [17:0] z;
    reg [3:0]  step;
    reg        busy;
    reg [17:0] atanTab;
    // atan(2^-i) with full turn = 2^18; z/4 maps 180 mechanical deg onto 16 bits
    always @* begin
        case (step)
            4'd0:    atanTab = 18'h08000;
            4'd1:    atanTab = 18'h04b90;
            4'd2:    atanTab = 18'h027ed;
            4'd3:    atanTab = 18'h01444;
            4'd4:    atanTab = 18'h00a2c;
            4'd5:    atanTab = 18'h00517;
            4'd6:    atanTab = 18'h0028c;
            4'd7:    atanTab = 18'h00146;
            4'd8:    atanTab = 18'h000a3;
            4'd9:    atanTab = 18'h00051;
            4'd10:   atanTab = 18'h00029;
            4'd11:   atanTab = 18'h00014;
            4'd12:   atanTab = 18'h0000a;
            default: atanTab = 18'h00005;
        endcase
    end
    wire signed [17:0] xs = x;
    wire signed [17:0] ys = y;
    wire signed [17:0] xsh = xs >>> step;
    wire signed [17:0] ysh = ys >>> step;
    always @(posedge mclk) begin
        if (reset) begin
            x <= 18'h00000;
            y <= 18'h00000;
            z <= 18'h00000;
            step <= 4'h0;
            busy <= 1'b0;
            done <= 1'b0;
            angle <= 16'h0000;
            magnitude <= 18'h00000;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                busy <= 1'b1;
                step <= 4'h0;
                // fold into right half plane, add 180 deg when x negative
                if (cosIn[15]) begin
                    x <= -{{2{cosIn[15]}}, cosIn};
                    y <= -{{2{sinIn[15]}}, sinIn};
                    z <= 18'h20000;
                end else begin
                    x <= {{2{cosIn[15]}}, cosIn};
                    y <= {{2{sinIn[15]}}, sinIn};
                    z <= 18'h00000;
                end
            end else if (busy) begin
                if (ys < 0) begin
                    x <= x - ysh;
                    y <= y + xsh;
                    z <= z - atanTab;
                end else begin
                    x <= x + ysh;
                    y <= y - xsh;
                    z <= z + atanTab;
                end
                if (step == ITER - 1) begin
                    busy <= 1'b0;
                end else begin
                    step <= step + 4'h1;
                end
            end
            if (busy && step == ITER - 1) begin
                done <= 1'b1;
                // half of the field angle is the mechanical angle, 180-degree periodic
                angle <= z[17:2];                    // see R2
                magnitude <= x;
            end
        end
    end
endmodule // acd_cordic

// ---- acd_core_asserts.sv ----
// port assertions for the angle core
`timescale 1ns/1ps
module acd_core_asserts (
    input wire        mclk,
    input wire        reset,
    input wire        adcValid,
    input wire        adcSel,
    input wire        psel,
    input wire        penable,
    input wire        pready,
    input wire        pslverr,
    input wire [11:0] dacCode,
    input wire        dacValid
);
    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    AST_RST_DIAG: assert property (disable iff (1'b0)
        reset |=> dacCode == 12'h010 && !dacValid) else $error("bad reset output");
    AST_VALID_PULSE: assert property (dacValid |=> !dacValid)
        else $error("valid pulse too long");
    AST_VALID_CAUSE: assert property (dacValid |-> $past(adcValid && adcSel, 17))
        else $error("code without sample pair");
    AST_VALID_BAND: assert property (dacValid |->
        (dacCode >= 12'h0a4 && dacCode <= 12'hf5c) || dacCode == 12'h010 || dacCode == 12'hff0)
        else $error("code in reserved band");
    AST_DIAG_HOLD: assert property (dacValid && dacCode == 12'hff0 |=>
        (dacCode == 12'hff0) [*8]) else $error("diag level left");
    AST_RDY_SETUP: assert property (psel && !penable |=> pready)
        else $error("no ready in access");
    AST_RDY_ACCESS: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    AST_RDY_ONE: assert property (pready |=> !pready)
        else $error("ready too long");
    AST_ERR_RDY: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule // acd_core_asserts

bind acd_angle_core acd_core_asserts u_chk (
    .mclk(mclk), .reset(reset), .adcValid(adcValid), .adcSel(adcSel),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .dacCode(dacCode), .dacValid(dacValid)
);

// ---- acd_dac_model.sv ----
// output dac and analog stage model
`timescale 1ns/1ps
module acd_dac_model (
    input  wire        mclk,
    input  wire        reset,
    input  wire [11:0] dacCode,
    output reg  [11:0] level,
    output reg         errBand
);
    // ****************************************
    // ratiometric level, reserved bands
    // ****************************************
    always @(posedge mclk) begin
        if (reset) begin
            level <= 12'h000;
            errBand <= 1'b1;
        end else begin
            level <= dacCode;
            errBand <= (dacCode < 12'h0a4) || (dacCode > 12'hf5c);
        end
    end
endmodule // acd_dac_model

// ---- acd_word_protect.v ----
// single-error-correcting, double-error-detecting 22-bit word protection
`timescale 1ns/1ps
module acd_word_protect (
    input  wire [21:0] codeIn,
    output reg  [15:0] dataOut,
    output reg         corrected,
    output reg         multiError
);
    // ********************************************************
    // syndrome over hamming positions 1..21, bit 0 is overall parity
    // ********************************************************
    reg [4:0]  syn;
    reg [21:0] fixed;
    reg        par;
    integer    i;
    integer    k;
    always @* begin
        syn = 5'h00;
        par = ^codeIn;
        for (i = 1; i < 22; i = i + 1) begin
            if (codeIn[i]) begin
                syn = syn ^ i[4:0];
            end
        end
        fixed = codeIn;
        corrected = 1'b0;
        multiError = 1'b0;
        if (syn != 5'h00 && par) begin
            corrected = 1'b1;                        // see R10
            fixed[syn] = ~codeIn[syn];
        end else if (syn != 5'h00 && !par) begin
            multiError = 1'b1;                       // see R11
        end else if (syn == 5'h00 && par) begin
            corrected = 1'b1;
        end
        dataOut = 16'h0000;
        k = 0;
        for (i = 3; i < 22; i = i + 1) begin
            if (i != 4 && i != 8 && i != 16) begin
                dataOut[k] = fixed[i];
                k = k + 1;
            end
        end
    end
endmodule // acd_word_protect

// ---- acdiag_map.vh ----
// register offsets, field positions, reset values and codes for the angle core
`ifndef ACDIAG_MAP_VH
`define ACDIAG_MAP_VH
// ********************************************************
// register byte offsets
// ********************************************************
`define ACD_CTRL        12'h000
`define ACD_ZERO        12'h004
`define ACD_RANGE       12'h008
`define ACD_CLAMP       12'h00c
`define ACD_SWITCH      12'h010
`define ACD_STATUS      12'h014
`define ACD_OUTPUT      12'h018
`define ACD_USER0       12'h01c
`define ACD_USER1       12'h020
`define ACD_IDENT       12'h024
`define ACD_MEMADDR     12'h028
`define ACD_MEMWDATA    12'h02c
`define ACD_MEMRDATA    12'h030
`define ACD_MAGMIN      12'h034
// ********************************************************
// control fields
// ********************************************************
`define ACD_CTRL_FALL   0
`define ACD_CTRL_ACTD   1
`define ACD_CTRL_DHIGH  2
`define ACD_CTRL_RESET  32'h0000_0000
// ********************************************************
// status fields
// ********************************************************
`define ACD_ST_CRCBAD   0
`define ACD_ST_MULTI    1
`define ACD_ST_MAGLOSS  2
`define ACD_ST_LOWSUP   3
`define ACD_ST_CORR     4
`define ACD_ST_DIAG     5
`define ACD_ST_READY    6
// ********************************************************
// reset values, 12-bit output code and 16-bit angle (0x10000 = 180 deg)
// ********************************************************
`define ACD_ZERO_RESET  16'h0000
`define ACD_RANGE_RESET 16'hc000
`define ACD_SW_RESET    16'he000
`define ACD_CLL_RESET   12'h0b0
`define ACD_CLU_RESET   12'hf4f
`define ACD_DIAG_LOW    12'h010
`define ACD_DIAG_HIGH   12'hff0
`define ACD_MAG_RESET   16'h0400
`define ACD_CRC_INIT    16'hffff
`define ACD_CRC_POLY    16'h1021
`define ACD_MEM_WORDS   16
`endif

// ---- tb_top.sv ----
// testbench for the angle core
`timescale 1ns/1ps
module tb_top;
    reg         mclk = 1'b0;
    reg         reset = 1'b1;
    reg         adcValid = 1'b0;
    reg         adcSel = 1'b0;
    reg  [15:0] adcData = 16'h0000;
    reg         lowSupply = 1'b0;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire        pready;
    wire        pslverr;
    wire [11:0] dacCode;
    wire        dacValid;
    wire [11:0] level;
    wire        errBand;
    integer     n_errors = 0;
    integer     comparisons = 0;
    integer     cycles = 0;
    integer     lat;
    integer     k;
    reg  [31:0] rd;
    reg         err;
    reg  [11:0] code;
    reg  [15:0] mem [0:15];
    localparam [63:0] TS = {16'he782, 16'hc4df, 16'h4000, 16'h0000};
    localparam [63:0] TC = {16'h3b21, 16'h187e, 16'h0000, 16'h4000};
    localparam [47:0] TR = {12'h0b0, 12'hf4f, 12'h58f, 12'h0b0};
    localparam [47:0] TF = {12'hf4f, 12'h0b0, 12'ha70, 12'hf4f};

    acd_angle_core dut (.mclk(mclk), .reset(reset), .adcValid(adcValid),
        .adcSel(adcSel), .adcData(adcData), .lowSupply(lowSupply), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .dacCode(dacCode),
        .dacValid(dacValid));
    acd_dac_model dac (.mclk(mclk), .reset(reset), .dacCode(dacCode),
        .level(level), .errBand(errBand));

    always #2 mclk = ~mclk;
    // ****************************************
    // helpers
    // ****************************************
    task end_sim;
        begin
            $display("errors %0d comparisons %0d", n_errors, comparisons);
            if (n_errors == 0 && comparisons > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    always @(posedge mclk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            end_sim;
        end
    end
    task chk(input ok, input [8*24-1:0] msg);
        begin
            comparisons = comparisons + 1;
            if (ok !== 1'b1) begin
                n_errors = n_errors + 1;
                $display("unexpected at %0t: %0s", $time, msg);
            end
        end
    endtask
    task apb(input wr, input [11:0] a, input [31:0] d);
        integer t;
        begin
            @(posedge mclk);
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge mclk);
            penable <= 1'b1;
            t = 0;
            @(posedge mclk);
            while (pready !== 1'b1 && t < 20) begin
                t = t + 1;
                @(posedge mclk);
            end
            chk(t < 20, "apb ready");
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task rst;
        integer t;
        begin
            @(posedge mclk);
            reset <= 1'b1;
            repeat (20) @(posedge mclk);
            chk(dacCode === 12'h010 && dacValid === 1'b0, "reset level");
            reset <= 1'b0;
            t = 0;
            rd = 32'h0;
            while (rd[6] !== 1'b1 && t < 40) begin
                apb(1'b0, 12'h014, 32'h0);
                t = t + 1;
            end
            chk(t < 40, "scan ready");
        end
    endtask
    function [15:0] crc(input [15:0] c, input [15:0] w);
        integer b;
        begin
            crc = c;
            for (b = 15; b >= 0; b = b - 1)
                crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ w[b]) ? 16'h1021 : 16'h0000);
        end
    endfunction
    task cfg(input [15:0] ctl, input bad);
        integer i;
        reg [15:0] c;
        begin
            mem[0] = ctl;
            c = 16'hffff;
            for (i = 0; i < 15; i = i + 1)
                c = crc(c, mem[i]);
            mem[15] = c ^ {15'h0, bad};
            for (i = 0; i < 16; i = i + 1) begin
                apb(1'b1, 12'h028, i);
                apb(1'b1, 12'h02c, {16'h0, mem[i]});
            end
            rst;
        end
    endtask
    task pair(input [15:0] s, input [15:0] c);
        begin
            @(posedge mclk);
            adcValid <= 1'b1;
            adcSel <= 1'b0;
            adcData <= s;
            @(posedge mclk);
            adcSel <= 1'b1;
            adcData <= c;
            @(posedge mclk);
            adcValid <= 1'b0;
            lat = 0;
            while (dacValid !== 1'b1 && lat < 40) begin
                @(posedge mclk);
                lat = lat + 1;
            end
            code = dacCode;
        end
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task t_angle(input fall);
        integer i;
        reg [11:0] e;
        begin
            cfg({15'h0, fall}, 1'b0);
            for (i = 0; i < 4; i = i + 1) begin
                pair(TS[i*16+:16], TC[i*16+:16]);
                chk(lat === 17, "latency");
                e = fall ? TF[i*12+:12] : TR[i*12+:12];
                chk(code + 12'h4 >= e && code <= e + 12'h4, "angle code");
                @(posedge mclk);
                chk(errBand === 1'b0, "valid band");
            end
        end
    endtask
    task t_regs;
        begin
            apb(1'b0, 12'h01c, 32'h0);
            chk(rd[15:0] === 16'h1234, "user0");
            apb(1'b0, 12'h020, 32'h0);
            chk(rd[15:0] === 16'h5678, "user1");
            apb(1'b0, 12'h024, 32'h0);
            chk(rd === 32'hbeefcafe || rd === 32'hcafebeef, "ident");
            apb(1'b1, 12'h028, 32'h6);
            apb(1'b0, 12'h030, 32'h0);
            chk(rd[15:0] === 16'h1234, "decoded word");
            apb(1'b0, 12'h014, 32'h0);
            chk(rd[0] === 1'b0 && rd[5] === 1'b0, "crc good");
            apb(1'b0, 12'hffc, 32'h0);
            chk(err === 1'b1, "unmapped");
            lowSupply <= 1'b1;
            apb(1'b0, 12'h014, 32'h0);
            chk(rd[3] === 1'b1, "low supply");
            lowSupply <= 1'b0;
        end
    endtask
    task t_diag;
        begin
            cfg(16'h0006, 1'b0);
            pair(16'h0000, 16'h0008);
            apb(1'b0, 12'h014, 32'h0);
            chk(rd[2] === 1'b1 && rd[5] === 1'b1, "magnet loss");
            chk(dacCode === 12'hff0 && errBand === 1'b1, "diag high");
            pair(16'h0000, 16'h4000);
            chk(dacCode === 12'hff0, "diag persists");
            cfg(16'h0002, 1'b1);
            apb(1'b0, 12'h014, 32'h0);
            chk(rd[0] === 1'b1, "crc bad");
            chk(dacCode === 12'h010 && rd[5] === 1'b1, "diag low");
        end
    endtask
    initial begin
        for (k = 0; k < 16; k = k + 1)
            mem[k] = 16'h0000;
        mem[2] = 16'hc000;
        mem[3] = 16'h00b0;
        mem[4] = 16'h0f4f;
        mem[5] = 16'he000;
        mem[6] = 16'h1234;
        mem[7] = 16'h5678;
        mem[8] = 16'hcafe;
        mem[9] = 16'hbeef;
        mem[10] = 16'h0400;
        rst;
        t_angle(1'b0);
        t_regs;
        t_angle(1'b1);
        t_diag;
        end_sim;
    end
endmodule // tb_top
